// ==== src/asbp_pkg.sv ====
/*
  timing and geometry constants for the static memory host controller.
  assumes a 250 MHz system clock; figures are for the fastest speed grade.
*/
package asbp_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ADDR_WIDTH = 19;
  localparam int DATA_WIDTH = 8;
  // nanosecond figures scaled to picoseconds
  localparam int WRITE_PULSE_PS = 10000;
  localparam int WRITE_DATA_SETUP_PS = 7000;
  localparam int ADDR_SETUP_END_PS = 10000;
  localparam int WRITE_CYCLE_PS = 12000;
  localparam int WRITE_OUTPUT_TURNOFF_PS = 6000;
  localparam int SELECT_ACCESS_PS = 12000;
  localparam int OUTPUT_ACCESS_PS = 6000;
  localparam int ADDR_ACCESS_PS = 12000;
  localparam int OUTPUT_RELEASE_PS = 6000;
  localparam int POWER_DOWN_PS = 12000;
  // minimum times round up to whole cycles
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WRITE_GAP_PS = WRITE_OUTPUT_TURNOFF_PS + WRITE_DATA_SETUP_PS;
  localparam int WRITE_LOW_CYC = (WRITE_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // waits before sampling include two synchroniser stages
  localparam int READ_WAIT_PS = SELECT_ACCESS_PS;
  localparam int READ_WAIT_CYC = (READ_WAIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 2;
  localparam int RELEASE_CYC = (OUTPUT_RELEASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_WIDTH = 4;
  localparam logic [CNT_WIDTH-1:0] CNT_ZERO = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 19'h00000;
  localparam logic [DATA_WIDTH-1:0] DATA_RESET = 8'h00;
endpackage

// ==== src/asbp_host.sv ====
/*
  host controller for an asynchronous 512K x 8 static memory.
  assumes one request at a time on a valid/ready port and data pins
  resolved outside from the output enable.
*/
`timescale 1ns/1ns
`default_nettype none
// Function
// - read: select, output enable low, write high
// - write: select and write enable low
// - write period is overlap of both strobes
// - data timed from terminating strobe edge
// - data set up 7 ns before end
// - address valid 10 ns before end
// - address may change at write end
// - address valid by write start
// - long enough for turnoff plus data setup
// - never drive while device drives lines
// - write enable high for every read
// - address valid before select falls (reads set address and drop select in the same cycle)
module asbp_host #(
  parameter int ADDR_W = asbp_pkg::ADDR_WIDTH,
  parameter int DATA_W = asbp_pkg::DATA_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic [ADDR_W-1:0] address_lines,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_enable_n,
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe
);
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ASBP_IDLE = 3'b000,
    ASBP_WSETUP = 3'b001,
    ASBP_WPULSE = 3'b011,
    ASBP_WEND = 3'b010,
    ASBP_RWAIT = 3'b110,
    ASBP_RDONE = 3'b111,
    ASBP_RREL = 3'b101
  } asbp_state_t;

  localparam int WLOW = (asbp_pkg::WRITE_PULSE_CYC > asbp_pkg::WRITE_LOW_CYC) ?
    asbp_pkg::WRITE_PULSE_CYC : asbp_pkg::WRITE_LOW_CYC;

  asbp_state_t state_reg, state_next;
  logic [asbp_pkg::CNT_WIDTH-1:0] cnt_reg, cnt_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic cs_n_reg, cs_n_next;
  logic oe_n_reg, oe_n_next;
  logic we_n_reg, we_n_next;
  logic drive_reg, drive_next;
  logic rsp_reg, rsp_next;
  logic [DATA_W-1:0] sync1_reg, sync2_reg;

  ////////////////////////////////////////////////////////////////////////
  // two-stage capture of the pins driven by the memory
  always_ff @(posedge clk)
  begin
    sync1_reg <= data_lines_in;
    sync2_reg <= sync1_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    cs_n_next = cs_n_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    drive_next = drive_reg;
    rsp_next = 1'b0;
    case (state_reg)
      ASBP_IDLE:
      begin
        if (req_valid)
        begin
          // address and data set a cycle before the write strobes fall; a read drops select and output enable with them
          addr_next = req_addr;
          wdata_next = req_wdata;
          we_n_next = 1'b1;
          if (req_write)
          begin
            oe_n_next = 1'b1;
            drive_next = 1'b1;
            state_next = ASBP_WSETUP;
          end
          else
          begin
            cs_n_next = 1'b0;
            oe_n_next = 1'b0;
            cnt_next = asbp_pkg::CNT_WIDTH'(asbp_pkg::READ_WAIT_CYC - 1);
            state_next = ASBP_RWAIT;
          end
        end
      end
      ASBP_WSETUP:
      begin
        // both strobes fall together; overlap is the write
        cs_n_next = 1'b0;
        we_n_next = 1'b0;
        cnt_next = asbp_pkg::CNT_WIDTH'(WLOW - 1);
        state_next = ASBP_WPULSE;
      end
      ASBP_WPULSE:
      begin
        if (cnt_reg == asbp_pkg::CNT_ZERO)
        begin
          // write enable rises first and terminates the write
          we_n_next = 1'b1;
          state_next = ASBP_WEND;
        end
        else
        begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      ASBP_WEND:
      begin
        // data and address held one cycle past the end
        // select rises a cycle after write enable, never with it
        cs_n_next = 1'b1;
        drive_next = 1'b0;
        state_next = ASBP_IDLE;
      end
      ASBP_RWAIT:
      begin
        if (cnt_reg == asbp_pkg::CNT_ZERO)
        begin
          rdata_next = sync2_reg;
          state_next = ASBP_RDONE;
        end
        else
        begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      ASBP_RDONE:
      begin
        // address stays put while the old read data drains
        rsp_next = 1'b1;
        cs_n_next = 1'b1;
        oe_n_next = 1'b1;
        cnt_next = asbp_pkg::CNT_WIDTH'(asbp_pkg::RELEASE_CYC);
        state_next = ASBP_RREL;
      end
      ASBP_RREL:
      begin
        // let the memory release its drivers before any later write
        if (cnt_reg == asbp_pkg::CNT_ZERO)
        begin
          state_next = ASBP_IDLE;
        end
        else
        begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default:
      begin
        state_next = ASBP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_reg <= ASBP_IDLE;
      cnt_reg <= asbp_pkg::CNT_ZERO;
      addr_reg <= asbp_pkg::ADDR_RESET;
      wdata_reg <= asbp_pkg::DATA_RESET;
      rdata_reg <= asbp_pkg::DATA_RESET;
      cs_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      drive_reg <= 1'b0;
      rsp_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      cs_n_reg <= cs_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      drive_reg <= drive_next;
      rsp_reg <= rsp_next;
    end
  end

  assign req_ready = (state_reg == ASBP_IDLE);
  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdata_reg;
  assign address_lines = addr_reg;
  assign chip_select_n = cs_n_reg;
  assign output_enable_n = oe_n_reg;
  assign write_enable_n = we_n_reg;
  assign data_lines_out = wdata_reg;
  assign data_lines_oe = drive_reg;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence wr_start_s;
    $fell(write_enable_n);
  endsequence

  no_fight_a: assert property (data_lines_oe |-> output_enable_n)
    else $error("host drives data while memory output enabled");
  read_we_a: assert property (!output_enable_n |-> write_enable_n)
    else $error("write enable low during read");
  wr_cs_a: assert property (!write_enable_n |-> !chip_select_n && data_lines_oe)
    else $error("write enable low without select and data");
  wr_len_a: assert property (wr_start_s |-> !write_enable_n [*4] ##1 write_enable_n)
    else $error("write pulse not four cycles");
  wr_end_a: assert property ($rose(write_enable_n) |-> !chip_select_n && data_lines_oe
      ##1 chip_select_n)
    else $error("write end order wrong");
  addr_hold_a: assert property (!chip_select_n |=> $stable(address_lines) || $past(chip_select_n))
    else $error("address moved while selected");
  rd_wait_a: assert property ($fell(output_enable_n) |-> !output_enable_n [*6] ##1 rsp_valid)
    else $error("read wait wrong");
  rel_gap_a: assert property ($rose(output_enable_n) |-> !data_lines_oe [*3])
    else $error("drive too soon after read");
endmodule
`default_nettype wire

// ==== verification/asbp_sram_model.sv ====
/*
  behavioural model of the asynchronous byte-wide static memory.
  assumes the host splits the data pins into data, enable and input.
*/
`timescale 1ns/1ns
`default_nettype none
module asbp_sram_model (
  input wire logic [18:0] address_lines,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic [7:0] host_data,
  input wire logic host_oe,
  output logic [7:0] bus,
  output logic clash
);
  logic [7:0] mem [0:524287];
  logic dev_en;
  logic wr_end;
  logic [7:0] rd;
  assign dev_en = !chip_select_n && !output_enable_n && write_enable_n;
  assign wr_end = chip_select_n | write_enable_n;
  assign #12 rd = mem[address_lines];
  // released lines show the inverse so a stale sample cannot pass
  assign bus = host_oe ? host_data : (dev_en ? rd : ~rd);
  assign clash = host_oe && dev_en;
  always @(posedge wr_end)
  begin
    mem[address_lines] <= host_data;
  end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
/*
  self-checking bench for the static memory host controller.
  assumes the behavioural memory model answers on the data pins.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [18:0] req_addr = 19'h00000;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, rsp_valid, cs_n, oe_n, we_n, d_oe, clash;
  logic [7:0] rsp_rdata, d_out, bus;
  logic [18:0] addr;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int we_low = 0;
  logic cs_n_d = 1'b1;
  logic [18:0] exp_addr = 19'h00000;
  always #2 clk = ~clk;
  asbp_host dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .address_lines(addr), .chip_select_n(cs_n), .output_enable_n(oe_n),
    .write_enable_n(we_n), .data_lines_in(bus), .data_lines_out(d_out), .data_lines_oe(d_oe));
  asbp_sram_model mem_model (.address_lines(addr), .chip_select_n(cs_n), .output_enable_n(oe_n),
    .write_enable_n(we_n), .host_data(d_out), .host_oe(d_oe), .bus(bus), .clash(clash));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      print_verdict;
    end
    if (reset_n)
    begin
      check1(clash, 1'b0);
      if (cs_n_d && !cs_n)
        check1(addr === exp_addr, 1'b1);
      cs_n_d = cs_n;
      if (!oe_n)
        check1(we_n, 1'b1);
      if (!we_n)
        we_low++;
      else if (we_low != 0)
      begin
        check1(we_low == 4, 1'b1);
        check1(cs_n, 1'b0);
        we_low = 0;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic do_req(input logic wr, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    exp_addr = a;
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    check1(req_ready, 1'b0);
  endtask
  task automatic do_read(input logic [18:0] a, input logic [7:0] exp);
    int n;
    do_req(1'b0, a, 8'h00);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check1(n < 12, 1'b1);
    check8(rsp_rdata, exp);
  endtask
  task test_boundary;
    do_req(1'b1, 19'h00000, 8'ha5);
    do_req(1'b1, 19'h7ffff, 8'h3c);
    do_read(19'h00000, 8'ha5);
    do_read(19'h7ffff, 8'h3c);
  endtask
  task test_overwrite;
    do_req(1'b1, 19'h12345, 8'h0f);
    do_req(1'b1, 19'h12345, 8'hf0);
    do_read(19'h12345, 8'hf0);
    do_read(19'h00000, 8'ha5);
  endtask
  task test_walk;
    for (int i = 0; i < 8; i++)
      do_req(1'b1, 19'h00100 + 19'(i), 8'h01 << i);
    for (int i = 0; i < 8; i++)
      do_read(19'h00100 + 19'(i), 8'h01 << i);
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    test_boundary;
    test_overwrite;
    test_walk;
    repeat (4) @(negedge clk);
    print_verdict;
  end
endmodule
`default_nettype wire
